/* File: hw/single_pin_debug_link.sv */
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
//
// Behaviour
// - Pin is open-drain half-duplex; never transmit while receiving.
// - Character: low start, eight data bits LSB first, 1.5 stop bits.
// - Idle after reset until 0x80 arrives; its eight-bit low sets rate.
// - Rate logic on system clock; periods up to 512 clocks supported.
// - Nine or more low bit times reset auto-baud; host resends 0x80.
// - Detect received break, low stop bit and transmit collision.
// - On error abort command, send four-character break, reset auto-baud.
// - Received break keeps control register and debug mode untouched.
// - Link held in reset during break until pin returns high.
// - Debug mode stops instruction fetch; clocks and peripherals keep running.
// - Debug entry leaves halt; watchdog refreshed while enabled in debug.
// - Breakpoint opcode with breakpoints enabled enters debug mode.
// - Breakpoints disabled: signal ignored, opcode runs as no-operation.
// - Pin low in last reset cycle enters debug mode after reset.
// - Debug mode left on flag write of 0 or any system reset.
// - Pin low in stop mode requests full system reset.
// - 16-bit runtime counter runs outside debug mode, saturates at 0xFFFF.
// - Runtime counter counts up from 0x0000.
// - Debug-mode flag is bit 7 of the debug control register.
module single_pin_debug_link
  import debug_link_pkg::*;
(
  input wire logic clk_sys,          // 125 MHz system clock
  input wire logic reset,            // Synchronous system reset, active high
  input wire logic psel,             // APB select
  input wire logic penable,          // APB enable
  input wire logic pwrite,           // APB direction
  input wire logic [7:0] paddr,      // APB byte address
  input wire logic [31:0] pwdata,    // APB write data
  output logic [31:0] prdata,        // APB read data
  output logic pready,               // APB ready
  output logic pslverr,              // APB error, unmapped address
  input wire logic debug_serial_pin_in, // Pin level seen at the pad
  output logic debug_serial_pin_out, // Pin output value, always low
  output logic debug_serial_pin_oe,  // High while pulling the pin low
  input wire logic brk_decoded,      // CPU decoded the breakpoint opcode
  input wire logic stop_mode,        // Device is in stop mode
  input wire logic wdt_enabled,      // Watchdog timer enabled
  output logic fetch_stop,           // Idle the CPU fetch unit
  output logic brk_as_nop,           // Breakpoint opcode runs as no-op
  output logic halt_exit,            // Pulse: leave halt mode
  output logic wdt_refresh,          // Watchdog refresh level
  output logic sys_reset_req,        // Request full system reset
  output logic cmd_abort             // Pulse: abort command in progress
);

  // ------------------------------------------------------------
  // Pin input and link state
  // ------------------------------------------------------------
  logic pin_level;
  link_state_t state;
  logic [CNT_W-1:0] timer;
  logic [5:0] bitn;
  logic [PERIOD_W-1:0] bit_period;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] rx_data;
  logic [7:0] tx_hold;
  logic tx_req;
  logic drive_low;
  logic [CNT_W-1:0] low_run;
  logic err_brk;
  logic err_frame;
  logic err_coll;
  logic rx_done;

  pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .pin_in(debug_serial_pin_in),
    .level(pin_level)
  );

  assign debug_serial_pin_out = 1'b0;
  assign debug_serial_pin_oe = drive_low;

  logic [CNT_W-1:0] period_w;
  logic [CNT_W-1:0] half_w;
  logic [CNT_W-1:0] brk_limit;
  logic tick;
  logic brk_now;
  logic frame_now;
  logic coll_now;
  logic go_error;

  assign period_w = CNT_W'(bit_period);
  assign half_w = CNT_W'(bit_period >> 1);
  assign brk_limit = CNT_W'(period_w * BREAK_BITS);
  assign tick = (timer == '0);

  // Own drive is excluded, so sending 0x00 never looks like a break
  assign brk_now = ((state == L_IDLE) || (state == L_RX) || (state == L_TX))
                   && !drive_low && (low_run >= brk_limit);
  assign frame_now = (state == L_RX) && tick && (bitn == STOP_IDX)
                     && !pin_level;
  // Checked at end of bit so the synchroniser lag cannot fake a clash
  assign coll_now = (state == L_TX) && tick && !drive_low && !pin_level;
  assign go_error = brk_now || frame_now || coll_now;

  // ------------------------------------------------------------
  // Low-run counter for break detection
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset || pin_level || drive_low) begin
      low_run <= '0;
    end else if (low_run != {CNT_W{1'b1}}) begin
      low_run <= low_run + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Link state machine: auto-baud, receiver, transmitter, break
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    err_brk <= 1'b0;
    err_frame <= 1'b0;
    err_coll <= 1'b0;
    rx_done <= 1'b0;
    if (reset) begin
      state <= L_UNLOCKED;
      timer <= '0;
      bitn <= '0;
      bit_period <= PERIOD_RST;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      rx_data <= 8'h00;
      drive_low <= 1'b0;
    end else if (go_error) begin
      err_brk <= brk_now;
      err_frame <= frame_now;
      err_coll <= coll_now;
      state <= L_BRK_OUT;
      drive_low <= 1'b1;
      timer <= period_w - 1'b1;
      bitn <= '0;
    end else begin
      case (state)
        L_UNLOCKED: begin
          drive_low <= 1'b0;
          if (!pin_level) begin
            state <= L_MEASURE;
            timer <= CNT_W'(1);
          end
        end
        L_MEASURE: begin
          if (pin_level) begin
            // Low span of 0x80 is start plus seven zeros: eight bits
            if ((timer >> 3) >= CNT_W'(PERIOD_MIN)
                && (timer >> 3) <= CNT_W'(PERIOD_MAX)) begin
              bit_period <= PERIOD_W'(timer / AUTOBAUD_LOW_BITS);
              state <= L_IDLE;
            end else begin
              state <= L_UNLOCKED;
            end
          end else if (timer >= UNLOCKED_BREAK_CYC) begin
            // No rate yet: answer the break at the slowest rate
            bit_period <= PERIOD_MAX;
            err_brk <= 1'b1;
            state <= L_BRK_OUT;
            drive_low <= 1'b1;
            timer <= CNT_W'(PERIOD_MAX) - 1'b1;
            bitn <= '0;
          end else begin
            timer <= timer + 1'b1;
          end
        end
        L_IDLE: begin
          if (!pin_level) begin
            state <= L_RX;
            timer <= half_w - 1'b1;
            bitn <= '0;
          end else if (tx_req) begin
            state <= L_TX;
            drive_low <= 1'b1;
            tx_shift <= tx_hold;
            timer <= period_w - 1'b1;
            bitn <= '0;
          end
        end
        L_RX: begin
          if (!tick) begin
            timer <= timer - 1'b1;
          end else if (bitn == '0 && pin_level) begin
            state <= L_IDLE; // glitch, not a start bit
          end else if (bitn == STOP_IDX) begin
            rx_data <= rx_shift;
            rx_done <= 1'b1;
            state <= L_IDLE;
          end else begin
            if (bitn != '0) begin
              rx_shift <= {pin_level, rx_shift[7:1]};
            end
            bitn <= bitn + 1'b1;
            timer <= period_w - 1'b1;
          end
        end
        L_TX: begin
          if (!tick) begin
            timer <= timer - 1'b1;
          end else if (bitn == STOP_IDX) begin
            state <= L_IDLE;
          end else if (bitn == 6'h08) begin
            drive_low <= 1'b0;
            bitn <= STOP_IDX;
            timer <= period_w + half_w - 1'b1;
          end else begin
            drive_low <= ~tx_shift[0];
            tx_shift <= tx_shift >> 1;
            bitn <= bitn + 1'b1;
            timer <= period_w - 1'b1;
          end
        end
        L_BRK_OUT: begin
          if (!tick) begin
            timer <= timer - 1'b1;
          end else if (bitn == BREAK_OUT_BITS - 1'b1) begin
            drive_low <= 1'b0;
            state <= L_WAIT_HIGH;
          end else begin
            bitn <= bitn + 1'b1;
            timer <= period_w - 1'b1;
          end
        end
        L_WAIT_HIGH: begin
          // Held here while the host still holds the line low
          if (pin_level) begin
            bit_period <= PERIOD_RST;
            state <= L_UNLOCKED;
          end
        end
        default: begin
          state <= L_UNLOCKED;
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] ctrl;
  logic rx_valid;
  logic st_brk;
  logic st_frame;
  logic st_coll;
  logic [15:0] runtime;
  logic debug_mode_flag;
  logic [31:0] rd_mux;

  assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_STATUS)
                   || (paddr == OFS_RUNTIME) || (paddr == OFS_BAUD)
                   || (paddr == OFS_RXDATA) || (paddr == OFS_TXDATA);
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux[7:0] = {debug_mode_flag, ctrl[6:0]};
      OFS_STATUS: begin
        rd_mux[ST_LOCKED_BIT] = (state != L_UNLOCKED) && (state != L_MEASURE)
                                && (state != L_WAIT_HIGH);
        rd_mux[ST_RX_VALID_BIT] = rx_valid;
        rd_mux[ST_TX_BUSY_BIT] = tx_req || (state == L_TX);
        rd_mux[ST_BRK_BIT] = st_brk;
        rd_mux[ST_FRAME_BIT] = st_frame;
        rd_mux[ST_COLL_BIT] = st_coll;
        rd_mux[ST_DBG_MODE_BIT] = debug_mode_flag;
      end
      OFS_RUNTIME: rd_mux[15:0] = runtime;
      OFS_BAUD: rd_mux[PERIOD_W-1:0] = bit_period;
      OFS_RXDATA: rd_mux[7:0] = rx_data;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup phase, so it comes from a flop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // Control bits other than the mode flag; a break never touches them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl <= CTRL_RST;
    end else if (wr_en && paddr == OFS_CTRL) begin
      ctrl <= pwdata[7:0];
    end
  end

  // Sticky status and receive flag: hardware set beats software clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_valid <= 1'b0;
      st_brk <= 1'b0;
      st_frame <= 1'b0;
      st_coll <= 1'b0;
    end else begin
      rx_valid <= rx_done || (rx_valid && !(rd_en && paddr == OFS_RXDATA) && !go_error);
      st_brk <= err_brk || (st_brk && !(wr_en && paddr == OFS_STATUS
                                         && pwdata[ST_BRK_BIT]));
      st_frame <= err_frame || (st_frame && !(wr_en && paddr == OFS_STATUS
                                               && pwdata[ST_FRAME_BIT]));
      st_coll <= err_coll || (st_coll && !(wr_en && paddr == OFS_STATUS
                                            && pwdata[ST_COLL_BIT]));
    end
  end

  // Transmit request; a locked-link error drops it with the command
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_req <= 1'b0;
      tx_hold <= 8'h00;
    end else if (go_error) begin
      tx_req <= 1'b0;
    end else if (wr_en && paddr == OFS_TXDATA && !tx_req) begin
      tx_req <= 1'b1;
      tx_hold <= pwdata[7:0];
    end else if (state == L_IDLE && pin_level && tx_req) begin
      tx_req <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_abort <= 1'b0;
    end else begin
      // An unlocked break aborts too, although it bypasses the error path
      cmd_abort <= go_error || (state == L_MEASURE && !pin_level
                                && timer >= UNLOCKED_BREAK_CYC);
    end
  end

  // ------------------------------------------------------------
  // Debug controller
  // ------------------------------------------------------------
  logic strap_low;
  logic reset_d;
  logic mode_d;

  always_ff @(posedge clk_sys) begin
    reset_d <= reset;
    if (reset) begin
      strap_low <= ~pin_level; // last reset cycle wins
    end
  end

  // Any system reset clears the flag; link breaks do not reach here
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      debug_mode_flag <= 1'b0;
    end else if (reset_d && strap_low) begin
      debug_mode_flag <= 1'b1;
    end else if (brk_decoded && ctrl[CTRL_BP_EN_BIT]) begin
      debug_mode_flag <= 1'b1;
    end else if (wr_en && paddr == OFS_CTRL) begin
      debug_mode_flag <= pwdata[CTRL_DBG_MODE_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_d <= 1'b0;
      halt_exit <= 1'b0;
      wdt_refresh <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      mode_d <= debug_mode_flag;
      halt_exit <= debug_mode_flag && !mode_d;
      wdt_refresh <= debug_mode_flag && wdt_enabled;
      sys_reset_req <= stop_mode && !pin_level;
    end
  end

  // Clock and peripherals are not gated here; only fetch stops
  assign fetch_stop = debug_mode_flag;
  assign brk_as_nop = brk_decoded && !ctrl[CTRL_BP_EN_BIT];

  // ------------------------------------------------------------
  // Runtime counter
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      runtime <= RUNTIME_RST;
    end else if (mode_d && !debug_mode_flag) begin
      runtime <= RUNTIME_RST;
    end else if (!debug_mode_flag && runtime != RUNTIME_MAX) begin
      runtime <= runtime + 1'b1;
    end
  end

endmodule

/* File: shared/debug_link_pkg.sv */
package debug_link_pkg;

  // ------------------------------------------------------------
  // Register map (APB byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RUNTIME = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0C;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  localparam logic [7:0] OFS_TXDATA = 8'h14;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int CTRL_DBG_MODE_BIT = 7;
  localparam int CTRL_BP_EN_BIT = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int ST_LOCKED_BIT = 0;
  localparam int ST_RX_VALID_BIT = 1;
  localparam int ST_TX_BUSY_BIT = 2;
  localparam int ST_BRK_BIT = 3;
  localparam int ST_FRAME_BIT = 4;
  localparam int ST_COLL_BIT = 5;
  localparam int ST_DBG_MODE_BIT = 6;
  localparam logic [15:0] RUNTIME_RST = 16'h0000;
  localparam logic [15:0] RUNTIME_MAX = 16'hFFFF;

  // ------------------------------------------------------------
  // Link timing, in system clocks or bit times
  // ------------------------------------------------------------
  localparam int PERIOD_W = 10;
  localparam int CNT_W = 14;
  localparam logic [PERIOD_W-1:0] PERIOD_MIN = 10'h004;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 10'h200;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 10'h200;
  localparam logic [CNT_W-1:0] AUTOBAUD_LOW_BITS = 14'h0008;
  localparam logic [CNT_W-1:0] BREAK_BITS = 14'h0009;
  localparam logic [CNT_W-1:0] UNLOCKED_BREAK_CYC = 14'h1200;
  localparam logic [5:0] STOP_IDX = 6'h09;
  localparam logic [5:0] BREAK_OUT_BITS = 6'h2A;
  localparam logic [7:0] AUTOBAUD_CHAR = 8'h80;
  localparam logic [7:0] BREAKPOINT_OPCODE = 8'h00;

  typedef enum logic [2:0] {
    L_UNLOCKED = 3'b000,
    L_MEASURE = 3'b001,
    L_IDLE = 3'b010,
    L_RX = 3'b011,
    L_TX = 3'b100,
    L_BRK_OUT = 3'b101,
    L_WAIT_HIGH = 3'b110
  } link_state_t;

endpackage

/* File: hw/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk_sys, // System clock
  input wire logic pin_in,  // Raw pin level
  output logic level        // Filtered, synchronised level
);
  // No reset here: the level must be live during system reset so the
  // debug strap can be caught in the last reset cycle.
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_sys) begin
    s1 <= pin_in;
    s2 <= s1;
    s3 <= s2;
  end

  // A change counts only once the second and third stages agree
  always_ff @(posedge clk_sys) begin
    if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule

/* File: bench/debug_link_checker.sv */
`timescale 1ns/1ps
module debug_link_checker
  import debug_link_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic psel, // APB
  input wire logic penable, // APB
  input wire logic pwrite, // APB
  input wire logic [7:0] paddr, // APB
  input wire logic [31:0] pwdata, // APB
  input wire logic [31:0] prdata, // APB
  input wire logic pready, // APB
  input wire logic pslverr, // APB
  input wire logic debug_serial_pin_in, // Pad level
  input wire logic debug_serial_pin_out, // Pin value
  input wire logic debug_serial_pin_oe, // Pin pull
  input wire logic brk_decoded, // CPU
  input wire logic stop_mode, // CPU
  input wire logic wdt_enabled, // CPU
  input wire logic fetch_stop, // CPU
  input wire logic brk_as_nop, // CPU
  input wire logic halt_exit, // CPU
  input wire logic wdt_refresh, // CPU
  input wire logic sys_reset_req, // CPU
  input wire logic cmd_abort // Link
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite && (paddr == OFS_CTRL);
  sequence s_halt_pulse;
    halt_exit ##1 !halt_exit;
  endsequence
  sequence s_break_out;
    debug_serial_pin_oe [*8];
  endsequence
  chk_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  chk_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  chk_pin_open_drain: assert property (!debug_serial_pin_out)
    else $error("pin driven high");
  chk_ctrl_flag: assert property (ctrl_wr && !brk_decoded |=>
    fetch_stop == $past(pwdata[CTRL_DBG_MODE_BIT])) else $error("debug flag write lost");
  chk_bp_enter: assert property (brk_decoded && !brk_as_nop |=> fetch_stop)
    else $error("breakpoint did not enter debug");
  chk_bp_ignored: assert property (brk_as_nop && !fetch_stop && !ctrl_wr
    |=> !fetch_stop) else $error("disabled breakpoint entered debug");
  chk_halt_leave: assert property ($rose(fetch_stop) |=> s_halt_pulse)
    else $error("halt exit pulse missing");
  chk_wdt_refresh: assert property (1'b1 |=>
    wdt_refresh == $past(fetch_stop && wdt_enabled)) else $error("watchdog refresh wrong");
  chk_stop_wake: assert property ((stop_mode && !debug_serial_pin_in) [*8]
    |-> ##[0:4] sys_reset_req) else $error("no reset request in stop");
  chk_wake_cause: assert property (sys_reset_req |-> $past(stop_mode))
    else $error("reset request outside stop");
  chk_abort_break: assert property (cmd_abort |-> ##[0:4] s_break_out)
    else $error("no break after abort");
  chk_abort_pulse: assert property (cmd_abort |=> !cmd_abort)
    else $error("abort longer than a cycle");
endmodule

bind single_pin_debug_link debug_link_checker u_chk (
  .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .debug_serial_pin_in, .debug_serial_pin_out, .debug_serial_pin_oe, .brk_decoded,
  .stop_mode, .wdt_enabled, .fetch_stop, .brk_as_nop, .halt_exit, .wdt_refresh,
  .sys_reset_req, .cmd_abort
);

/* File: bench/host_link.sv */
`timescale 1ns/1ps
module host_link (
  input wire logic clk_sys, // System clock
  input wire logic pin, // Resolved pin level
  output logic host_oe // High while host pulls pin low
);
  int period = 512;
  initial host_oe = 1'b0;
  task automatic hold(input logic v, input int n);
    host_oe <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic send_char(input logic [7:0] d, input logic stop_ok);
    hold(1'b1, period);
    for (int i = 0; i < 8; i++) hold(~d[i], period);
    hold(~stop_ok, period);
    hold(1'b0, period / 2);
  endtask
  task automatic wait_high(input int n, output logic ok);
    int run;
    int t;
    run = 0;
    t = 0;
    while (run < n && t < 40000) begin
      @(posedge clk_sys);
      run = pin ? run + 1 : 0;
      t++;
    end
    ok = (run >= n);
  endtask
  task automatic wait_start();
    int t;
    t = 0;
    while (pin !== 1'b0 && t < 2000) begin
      @(posedge clk_sys);
      t++;
    end
  endtask
  task automatic recv_char(output logic [7:0] d, output logic stop);
    wait_start();
    repeat (period + period / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      d[i] = pin;
      repeat (period) @(posedge clk_sys);
    end
    stop = pin;
    // Let the device finish its stop time before the host may talk
    repeat (period) @(posedge clk_sys);
  endtask
  // Deliberate overlap with a device character
  task automatic collide();
    wait_start();
    repeat (2 * period) @(posedge clk_sys);
    hold(1'b1, 2 * period);
    hold(1'b0, 1);
  endtask
endmodule

/* File: bench/test_single_pin_debug_link.sv */
`timescale 1ns/1ps
module test_single_pin_debug_link
  import debug_link_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic brk_decoded = 1'b0;
  logic stop_mode = 1'b0;
  logic wdt_enabled = 1'b0;
  logic [31:0] prdata, rdat, rsave;
  logic pready, pslverr, debug_serial_pin_out, debug_serial_pin_oe, fetch_stop, brk_as_nop;
  logic halt_exit, wdt_refresh, sys_reset_req, cmd_abort, host_oe, pin, rerr, ok, stp;
  logic [7:0] rx;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int aborts = 0;
  assign pin = !(host_oe || debug_serial_pin_oe);
  single_pin_debug_link DUT (
    .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .debug_serial_pin_in(pin), .debug_serial_pin_out, .debug_serial_pin_oe, .brk_decoded,
    .stop_mode, .wdt_enabled, .fetch_stop, .brk_as_nop, .halt_exit, .wdt_refresh,
    .sys_reset_req, .cmd_abort
  );
  host_link host (.clk_sys, .pin, .host_oe);
  initial forever #4 clk_sys = ~clk_sys;
  // Ceiling covers two 512-clock breaks plus the saturation wait
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cmd_abort === 1'b1) aborts <= aborts + 1;
    if (cyc == 90000) begin
      error_cnt++;
      $display("Error %0t: timeout", $time);
      end_of_test();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the bench timeout ends this wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Recovery after any link error, then relock at the host's rate
  task automatic link_err(input int bit_idx, input int n);
    host.wait_high(64, ok);
    check1(ok, 1'b1);
    rd(OFS_STATUS);
    check1(rdat[bit_idx], 1'b1);
    check1(rdat[ST_LOCKED_BIT], 1'b0);
    check32(aborts, n);
    wr(OFS_STATUS, 32'h00000038);
    host.send_char(AUTOBAUD_CHAR, 1'b1);
    rd(OFS_BAUD);
    check32(rdat, host.period);
    rd(OFS_STATUS);
    check1(rdat[ST_LOCKED_BIT], 1'b1);
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    rd(OFS_CTRL);
    check32(rdat, {24'h000000, CTRL_RST});
    rd(OFS_STATUS);
    check32(rdat, 32'h00000000);
    rd(OFS_BAUD);
    check32(rdat, {22'h000000, PERIOD_RST});
    rd(8'h18);
    check1(rerr, 1'b1);
    check32(rdat, 32'h00000000);
    $display("Test reset done");
    host.hold(1'b1, 5000);
    host.hold(1'b0, 1);
    link_err(ST_BRK_BIT, 1);
    host.send_char(8'hA5, 1'b1);
    rd(OFS_STATUS);
    check1(rdat[ST_RX_VALID_BIT], 1'b1);
    rd(OFS_RXDATA);
    check32(rdat, 32'h000000A5);
    rd(OFS_STATUS);
    check1(rdat[ST_RX_VALID_BIT], 1'b0);
    $display("Test slow link done");
    host.hold(1'b1, 12 * 512);
    host.hold(1'b0, 1);
    host.period = 16;
    link_err(ST_BRK_BIT, 2);
    while (cyc < 66000) @(posedge clk_sys);
    rd(OFS_RUNTIME);
    check32(rdat, {16'h0000, RUNTIME_MAX});
    wr(OFS_TXDATA, 32'h0000003C);
    host.recv_char(rx, stp);
    check32(rx, 32'h0000003C);
    check1(stp, 1'b1);
    $display("Test break and transmit done");
    host.send_char(8'h5A, 1'b0);
    link_err(ST_FRAME_BIT, 3);
    wr(OFS_TXDATA, 32'h000000FF);
    host.collide();
    link_err(ST_COLL_BIT, 4);
    $display("Test serial errors done");
    wdt_enabled <= 1'b1;
    wr(OFS_CTRL, 32'h00000080);
    settle(2);
    check1(fetch_stop, 1'b1);
    check1(wdt_refresh, 1'b1);
    host.hold(1'b1, 12 * 16);
    host.hold(1'b0, 1);
    link_err(ST_BRK_BIT, 5);
    rd(OFS_CTRL);
    check32(rdat, 32'h00000080);
    rd(OFS_STATUS);
    check1(rdat[ST_DBG_MODE_BIT], 1'b1);
    wr(OFS_CTRL, 32'h00000000);
    rd(OFS_RUNTIME);
    check1(rdat < 32'h00000010, 1'b1);
    check1(fetch_stop, 1'b0);
    // Re-enter before saturation so a counter that runs on is visible
    wr(OFS_CTRL, 32'h00000080);
    rd(OFS_RUNTIME);
    rsave = rdat;
    rd(OFS_RUNTIME);
    check32(rdat, rsave);
    check1(rsave != 32'h00000000, 1'b1);
    $display("Test debug mode done");
    wr(OFS_CTRL, 32'h00000020);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      brk_decoded <= 1'b1;
      settle(1);
      check1(brk_as_nop, k[0]);
      @(posedge clk_sys);
      brk_decoded <= 1'b0;
      settle(2);
      check1(fetch_stop, ~k[0]);
      rd(OFS_CTRL);
      check32(rdat, k[0] ? 32'h00000000 : 32'h000000A0);
      wr(OFS_CTRL, 32'h00000000);
    end
    $display("Test breakpoints done");
    @(posedge clk_sys);
    stop_mode <= 1'b1;
    host.hold(1'b1, 16);
    check1(sys_reset_req, 1'b1);
    host.hold(1'b0, 1);
    stop_mode <= 1'b0;
    reset <= 1'b1;
    host.hold(1'b1, 12);
    reset <= 1'b0;
    host.hold(1'b0, 3);
    #1;
    check1(fetch_stop, 1'b1);
    rd(OFS_CTRL);
    check32(rdat[7:0], 32'h00000080);
    $display("Test stop and strap done");
    end_of_test();
  end
endmodule
